/* prpi_ctrl.sv */
// reset sequencer, power-save control and interrupt logic of a phy
// assumes the management port delivers one-cycle read/write strobes
// and that every input is synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] host holds reset pin low at least 1us
// [R2] hardware reset restores defaults, relatches straps
// [R3] internal reset ends about 200us after release
// [R4] basic control bit15 resets only registers 0x00-0x07
// [R5] global reset clears all registers, keeps straps
// [R6] restart bit resets circuits, keeps registers
// [R7] software reset or restart ends after 200us
// [R8] host waits 500us after software reset
// [R9] shared pin input by default, bit0 makes output
// [R10] control register holds interrupt enable and polarity
// [R11] shared pin input driven low enters power-down
// [R12] pin low at reset release starts powered down
// [R13] sources disabled by default, enable bit each
// [R14] enabled interrupt condition drives pin active
// [R15] status shows pending bits, read clears all
// [R16] pin low or bit11 enters ieee power down
// [R17] power-save enable bit14, mode bits 13:12
// [R18] clearing mode bits resumes prior operating state
// [R19] strap autoneg starts after any reset completes; a plain restart starts none here
// [R20] disabled or mode 00 means normal operation
module prpi_ctrl #(
  parameter int RESET_DONE_CYCLES = prpi_pkg::RESET_DONE_CYC,
  parameter int NUM_IRQ = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hw_resetn,
  input wire logic i_autoneg_strap_enable,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic [NUM_IRQ-1:0] i_irq_event,
  input wire logic i_pin_in,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_circuit_reset,
  output logic o_autoneg_start,
  output logic o_power_down,
  output logic o_low_power_active,
  output logic o_low_power_passive
);

  // ==========================================================
  // decode and reset requests
  typedef enum logic {
    SEQ_IDLE,
    SEQ_BUSY
  } prpi_seq_t;

  localparam int CNT_W = $clog2(RESET_DONE_CYCLES + 1);

  prpi_seq_t seq_q;
  logic [CNT_W-1:0] cnt_q;
  logic hw_low_q;
  logic strap_an_q;
  logic [15:0] bmc_q;
  logic [15:0] psc_q;
  logic [NUM_IRQ-1:0] irq_en_q;
  logic [NUM_IRQ-1:0] irq_pend_q;
  logic std_reset_q;
  logic glob_reset_q;
  logic restart_q;
  logic an_pending_q;

  logic wr_bmc;
  logic wr_psc;
  logic wr_ise1;
  logic wr_ise2;
  logic wr_prc;
  logic rd_ise;
  logic hw_low;
  logic glob_clear;
  logic req_std;
  logic req_glob;
  logic req_restart;
  logic seq_done;
  logic pin_pd;
  logic [1:0] ps_mode;
  logic ps_en;

  // the reset pin is taken as synchronous, so a low level acts at once
  assign hw_low = !i_hw_resetn; // [R1]

  // address decode of the management accesses
  always_comb begin
    wr_bmc = 1'b0;
    wr_psc = 1'b0;
    wr_ise1 = 1'b0;
    wr_ise2 = 1'b0;
    wr_prc = 1'b0;
    if (i_reg_addr == prpi_pkg::ADDR_BASIC_MODE_CONTROL) begin
      wr_bmc = i_reg_wr;
    end else if (i_reg_addr == prpi_pkg::ADDR_PHY_SPECIFIC_CONTROL) begin
      wr_psc = i_reg_wr;
    end else if (i_reg_addr == prpi_pkg::ADDR_IRQ_STATUS_ENABLE_1) begin
      wr_ise1 = i_reg_wr;
    end else if (i_reg_addr == prpi_pkg::ADDR_IRQ_STATUS_ENABLE_2) begin
      wr_ise2 = i_reg_wr;
    end else if (i_reg_addr == prpi_pkg::ADDR_PHY_RESET_CONTROL) begin
      wr_prc = i_reg_wr;
    end
  end

  // either status register read clears every pending bit
  assign rd_ise = i_reg_rd &&
    (i_reg_addr == prpi_pkg::ADDR_IRQ_STATUS_ENABLE_1 ||
     i_reg_addr == prpi_pkg::ADDR_IRQ_STATUS_ENABLE_2); // [R15]

  assign req_std = wr_bmc && i_reg_wdata[prpi_pkg::BMC_RESET_BIT];
  assign req_glob = wr_prc &&
    i_reg_wdata[prpi_pkg::PRC_GLOBAL_RESET_BIT];
  assign req_restart = wr_prc && i_reg_wdata[prpi_pkg::PRC_RESTART_BIT];

  // a global reset wipes the register file the cycle it is written
  assign glob_clear = !i_resetn || hw_low || req_glob; // [R2] [R5]

  // ==========================================================
  // reset sequencer
  assign seq_done = (seq_q == SEQ_BUSY) &&
    (cnt_q == CNT_W'(RESET_DONE_CYCLES - 1));

  // one counter serves every reset kind; a new request restarts it
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      seq_q <= SEQ_BUSY;
      cnt_q <= '0;
    end else if (hw_low) begin
      seq_q <= SEQ_BUSY; // [R3]
      cnt_q <= '0;
    end else if (req_std || req_glob || req_restart) begin
      seq_q <= SEQ_BUSY; // [R7]
      cnt_q <= '0;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          cnt_q <= '0;
        end
        SEQ_BUSY: begin
          if (seq_done) begin
            seq_q <= SEQ_IDLE; // [R3] [R7]
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          seq_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // remember the pin held low, to report the hardware release
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hw_low_q <= 1'b1;
    end else begin
      hw_low_q <= hw_low;
    end
  end

  // straps are caught while the reset pin is low, never on a soft reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn || hw_low) begin
      strap_an_q <= i_autoneg_strap_enable; // [R2]
    end
  end

  // self-clearing reset bits read back one while their reset runs
  always_ff @(posedge i_clk) begin
    if (!i_resetn || hw_low) begin
      std_reset_q <= 1'b0;
      glob_reset_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      // a request landing on the final count must still read back one
      if (seq_done) begin
        std_reset_q <= 1'b0;
        glob_reset_q <= 1'b0;
        restart_q <= 1'b0;
      end
      if (req_std) begin
        std_reset_q <= 1'b1; // [R4]
      end
      if (req_glob) begin
        glob_reset_q <= 1'b1; // [R5]
      end
      if (req_restart) begin
        restart_q <= 1'b1; // [R6]
      end
    end
  end

  // autonegotiation is armed by a hardware or software reset only;
  // a plain restart keeps whatever link the phy had
  always_ff @(posedge i_clk) begin
    if (!i_resetn || hw_low) begin
      an_pending_q <= 1'b1; // [R19]
    end else if (req_std || req_glob) begin
      an_pending_q <= 1'b1; // [R19]
    end else if (seq_done) begin
      an_pending_q <= 1'b0;
    end
  end

  // ==========================================================
  // register file
  // basic mode control; the standard reset hits only 0x00-0x07,
  // and of those only this one is held here
  always_ff @(posedge i_clk) begin
    if (glob_clear) begin
      bmc_q <= prpi_pkg::BMC_RESET_VAL;
      bmc_q[prpi_pkg::BMC_AN_ENABLE_BIT] <= strap_an_q;
    end else if (req_std) begin
      bmc_q <= prpi_pkg::BMC_RESET_VAL; // [R4]
      bmc_q[prpi_pkg::BMC_AN_ENABLE_BIT] <= strap_an_q;
    end else if (wr_bmc) begin
      bmc_q <= i_reg_wdata;
      bmc_q[prpi_pkg::BMC_RESET_BIT] <= 1'b0;
      bmc_q[prpi_pkg::BMC_AN_RESTART_BIT] <= 1'b0;
    end
  end

  // phy specific control; untouched by standard reset and restart
  always_ff @(posedge i_clk) begin
    if (glob_clear) begin
      psc_q <= prpi_pkg::PSC_RESET_VAL; // [R9] [R6]
    end else if (wr_psc) begin
      psc_q <= i_reg_wdata; // [R10] [R17]
    end
  end

  // per-source enables, low byte of each status register
  always_ff @(posedge i_clk) begin
    if (glob_clear) begin
      irq_en_q <= '0; // [R13]
    end else begin
      if (wr_ise1) begin
        irq_en_q[7:0] <= i_reg_wdata[7:0]; // [R13]
      end
      if (wr_ise2) begin
        irq_en_q[NUM_IRQ-1:8] <= i_reg_wdata[NUM_IRQ-9:0];
      end
    end
  end

  // pending bits; an event in the clearing cycle survives the read
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g = g + 1) begin : g_pend
      always_ff @(posedge i_clk) begin
        if (glob_clear) begin
          irq_pend_q[g] <= 1'b0;
        end else if (i_irq_event[g] && irq_en_q[g]) begin
          irq_pend_q[g] <= 1'b1; // [R15]
        end else if (rd_ise) begin
          irq_pend_q[g] <= 1'b0; // [R15]
        end
      end
    end
  endgenerate

  // registered read data, answered one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd) begin
        o_reg_rdata <= 16'h0000;
      end else if (i_reg_addr ==
                   prpi_pkg::ADDR_BASIC_MODE_CONTROL) begin
        o_reg_rdata <= bmc_q | {std_reset_q, 15'h0000};
      end else if (i_reg_addr ==
                   prpi_pkg::ADDR_PHY_SPECIFIC_CONTROL) begin
        o_reg_rdata <= psc_q;
      end else if (i_reg_addr ==
                   prpi_pkg::ADDR_IRQ_STATUS_ENABLE_1) begin
        o_reg_rdata <= {irq_pend_q[7:0], irq_en_q[7:0]};
      end else if (i_reg_addr ==
                   prpi_pkg::ADDR_IRQ_STATUS_ENABLE_2) begin
        o_reg_rdata <= {irq_pend_q[NUM_IRQ-1:8], irq_en_q[NUM_IRQ-1:8]};
      end else if (i_reg_addr ==
                   prpi_pkg::ADDR_PHY_RESET_CONTROL) begin
        o_reg_rdata <= {glob_reset_q, restart_q, 14'h0000};
      end else begin
        o_reg_rdata <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // shared pin and power modes
  // weak pull-up keeps the pin high unless something pulls it low;
  // the registered direction is used so our own last driven low level
  // is not mistaken for a power-down request while the pin is released
  assign pin_pd = !o_pin_oe && !i_pin_in; // [R11]
  assign ps_en = psc_q[prpi_pkg::PSC_PS_ENABLE_BIT];
  assign ps_mode = psc_q[prpi_pkg::PSC_PS_MODE_LSB +: 2];

  // pin direction and interrupt level; registered, so the pin moves
  // one clock after the pending bit, a trade for glitch-free output
  always_ff @(posedge i_clk) begin
    if (!i_resetn || hw_low) begin
      o_pin_oe <= 1'b0; // [R9]
      o_pin_out <= 1'b1;
    end else begin
      o_pin_oe <= psc_q[prpi_pkg::PSC_INT_OE_BIT]; // [R9]
      if (psc_q[prpi_pkg::PSC_INT_EN_BIT] && (|irq_pend_q)) begin
        o_pin_out <= psc_q[prpi_pkg::PSC_INT_POL_BIT]; // [R14] [R10]
      end else begin
        o_pin_out <= !psc_q[prpi_pkg::PSC_INT_POL_BIT];
      end
    end
  end

  // power modes; the rest of the phy keeps its state while down, so
  // dropping these levels resumes where it left off
  always_ff @(posedge i_clk) begin
    if (!i_resetn || hw_low) begin
      o_power_down <= 1'b0;
      o_low_power_active <= 1'b0;
      o_low_power_passive <= 1'b0;
    end else begin
      o_power_down <= pin_pd || // [R11] [R12] [R16]
        bmc_q[prpi_pkg::BMC_POWER_DOWN_BIT] || // [R16]
        (ps_en && ps_mode == prpi_pkg::PS_MODE_POWER_DOWN); // [R17]
      o_low_power_active <= ps_en &&
        (ps_mode == prpi_pkg::PS_MODE_LP_ACTIVE); // [R17] [R20]
      o_low_power_passive <= ps_en &&
        (ps_mode == prpi_pkg::PS_MODE_LP_PASSIVE); // [R17] [R18]
    end
  end

  // ==========================================================
  // sequencer outputs
  // circuits stay in reset for the whole sequence of every kind
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_circuit_reset <= 1'b1;
    end else begin
      o_circuit_reset <= hw_low || hw_low_q ||
        (seq_q == SEQ_BUSY && !seq_done); // [R3] [R6] [R7]
    end
  end

  // one-cycle start pulse when a hardware or software reset finishes with the strap set
  always_ff @(posedge i_clk) begin
    if (!i_resetn || hw_low) begin
      o_autoneg_start <= 1'b0;
    end else begin
      o_autoneg_start <= seq_done && an_pending_q && strap_an_q; // [R19]
    end
  end

endmodule : prpi_ctrl

`default_nettype wire

/* prpi_pkg.sv */
// constants for the reset, power-down and interrupt controller
// assumes a 50 MHz core clock and a 5-bit management register address
package prpi_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 50;
  localparam int HW_RESET_MIN_NS = 1000;
  localparam int RESET_DONE_US = 200;
  localparam int SW_RESET_WAIT_US = 500;
  localparam int RESET_DONE_CYC = RESET_DONE_US * CLK_MHZ;
  localparam int HW_RESET_MIN_CYC =
    (HW_RESET_MIN_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // register offsets
  localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_STD_LAST = 5'h07;
  localparam logic [4:0] ADDR_PHY_SPECIFIC_CONTROL = 5'h11;
  localparam logic [4:0] ADDR_IRQ_STATUS_ENABLE_1 = 5'h12;
  localparam logic [4:0] ADDR_IRQ_STATUS_ENABLE_2 = 5'h13;
  localparam logic [4:0] ADDR_PHY_RESET_CONTROL = 5'h1F;

  // ==========================================================
  // basic_mode_control fields
  localparam int BMC_RESET_BIT = 15;
  localparam int BMC_AN_ENABLE_BIT = 12;
  localparam int BMC_POWER_DOWN_BIT = 11;
  localparam int BMC_AN_RESTART_BIT = 9;
  localparam logic [15:0] BMC_RESET_VAL = 16'h0000;

  // phy_specific_control fields
  localparam int PSC_PS_ENABLE_BIT = 14;
  localparam int PSC_PS_MODE_LSB = 12;
  localparam int PSC_INT_POL_BIT = 2;
  localparam int PSC_INT_EN_BIT = 1;
  localparam int PSC_INT_OE_BIT = 0;
  localparam logic [15:0] PSC_RESET_VAL = 16'h0000;
  localparam logic [1:0] PS_MODE_NONE = 2'h0;
  localparam logic [1:0] PS_MODE_POWER_DOWN = 2'h1;
  localparam logic [1:0] PS_MODE_LP_ACTIVE = 2'h2;
  localparam logic [1:0] PS_MODE_LP_PASSIVE = 2'h3;

  // irq_status_enable_n: status in high byte, enables in low byte
  localparam int ISE_STATUS_LSB = 8;
  localparam logic [7:0] ISE_ENABLE_RESET_VAL = 8'h00;

  // phy_reset_control fields
  localparam int PRC_GLOBAL_RESET_BIT = 15;
  localparam int PRC_RESTART_BIT = 14;

  typedef enum logic [1:0] {
    RST_NONE,
    RST_STD,
    RST_GLOBAL,
    RST_RESTART
  } prpi_rst_kind_t;

endpackage : prpi_pkg

/* prpi_ctrl_sva.sv */
// checker for the reset, power-save and interrupt controller ports
// assumes it is bound onto prpi_ctrl with the same reset count
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker
module prpi_ctrl_chk #(
  parameter int RESET_DONE_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hw_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_pin_in,
  input wire logic o_pin_oe,
  input wire logic o_circuit_reset,
  input wire logic o_autoneg_start,
  input wire logic o_power_down,
  input wire logic o_low_power_active,
  input wire logic o_low_power_passive
);
  logic [15:0] run_q;
  logic wr_q;
  // length of the running circuit reset, zero while a reset is held
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_hw_resetn || !o_circuit_reset) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
  // a write one cycle back may still be moving the pin mode
  always_ff @(posedge i_clk) begin
    wr_q <= i_reg_wr;
  end
  rst_idle_a: assert property (@(posedge i_clk)
    (!i_resetn || !i_hw_resetn) |=> !o_pin_oe && !o_power_down
    && o_circuit_reset) else $error("outputs not idle in reset");
  pd_pin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_hw_resetn && !o_pin_oe && !i_pin_in && !i_reg_wr && !wr_q
    |=> o_power_down) else $error("pin low gave no power down");
  pd_reg_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_reg_wr && i_reg_addr == 5'h00 && i_reg_wdata[11]
    && !i_reg_wdata[15] |-> ##[1:2] o_power_down)
    else $error("control bit gave no power down");
  lpa_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_reg_wr && i_reg_addr == 5'h11 && i_reg_wdata[15:12] == 4'h6
    |-> ##[1:2] o_low_power_active) else $error("no active saving");
  lpp_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_reg_wr && i_reg_addr == 5'h11 && i_reg_wdata[15:12] == 4'h7
    |-> ##[1:2] o_low_power_passive) else $error("no passive saving");
  ps_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_reg_wr && i_reg_addr == 5'h11 && !i_reg_wdata[14] |-> ##2
    !o_low_power_active && !o_low_power_passive)
    else $error("saving mode while disabled");
  cr_end_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(o_circuit_reset) |-> run_q >= RESET_DONE_CYCLES - 1
    && run_q <= RESET_DONE_CYCLES + 2) else $error("reset length off");
  cr_bound_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_circuit_reset |-> run_q <= RESET_DONE_CYCLES + 2)
    else $error("circuit reset overran");
  an_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_autoneg_start |-> ($past(o_circuit_reset) ||
    $past(o_circuit_reset, 2)) ##1 !o_autoneg_start)
    else $error("autoneg start misplaced");
  rd_ans_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_reg_rd && i_hw_resetn |=> o_reg_rvalid ##1
    (o_reg_rvalid || o_reg_rdata == 16'h0000))
    else $error("read not answered");
endmodule : prpi_ctrl_chk
`default_nettype wire

/* prpi_host.sv */
// management host model: reset pin, register strobes, pin pull-down
// assumes the bench resolves the shared pin with its pull-up
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host model
module prpi_host #(
  parameter int HOLD_CYCLES = 50,
  parameter int SOFT_WAIT = 50
) (
  input wire logic i_clk,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic o_hw_resetn,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [4:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  output logic o_pin_low
);
  // idle bus levels at time zero
  initial begin
    o_hw_resetn = 1'b1;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 5'h00;
    o_reg_wdata = 16'h0000;
    o_pin_low = 1'b0;
  end
  // stale address and data are inverted so nothing leans on them
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rvalid ? i_reg_rdata : 16'hDEAD;
  endtask : rd
  // reset pin held low for the minimum pulse width
  task automatic hw_reset();
    @(negedge i_clk);
    o_hw_resetn = 1'b0;
    repeat (HOLD_CYCLES) @(negedge i_clk);
    o_hw_resetn = 1'b1;
  endtask : hw_reset
  task automatic soft_wait();
    repeat (SOFT_WAIT) @(negedge i_clk);
  endtask : soft_wait
endmodule : prpi_host
`default_nettype wire

/* test_phy_reset_power_irq_ctrl.sv */
// bench for the reset, power-save and interrupt controller
// assumes a shortened reset count; the host model drives the port
`timescale 1ns/1ps
`default_nettype none
module test_phy_reset_power_irq_ctrl;
  localparam int RDC = 20;
  logic clk = 1'b0, resetn = 1'b0, strap = 1'b1, hw_n, wr, rd, rv;
  logic [4:0] addr;
  logic [15:0] wd, rdat, irq = 16'h0000;
  logic pin_low, pin_in, p_out, p_oe, cr, an, pd, lpa, lpp;
  int fails = 0, check_count = 0, an_cnt = 0;
  // weak pull-up unless a party pulls the pin
  assign pin_in = p_oe ? p_out : !pin_low;
  always #10 clk = ~clk;
  // count autoneg pulses at the edge they stand
  always @(posedge clk) if (an === 1'b1) an_cnt <= an_cnt + 1;
  prpi_ctrl #(.RESET_DONE_CYCLES(RDC)) i_dut (.i_clk(clk),
    .i_resetn(resetn), .i_hw_resetn(hw_n), .i_autoneg_strap_enable(strap),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_irq_event(irq),
    .i_pin_in(pin_in), .o_pin_out(p_out), .o_pin_oe(p_oe),
    .o_circuit_reset(cr), .o_autoneg_start(an), .o_power_down(pd),
    .o_low_power_active(lpa), .o_low_power_passive(lpp));
  prpi_host #(.HOLD_CYCLES(prpi_pkg::HW_RESET_MIN_CYC),
    .SOFT_WAIT(RDC * 5 / 2)) i_host (
    .i_clk(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv), .o_hw_resetn(hw_n),
    .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wd),
    .o_pin_low(pin_low));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask : rc
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic pulse(input logic [15:0] v);
    @(negedge clk);
    irq = v;
    @(negedge clk);
    irq = 16'h0000;
  endtask : pulse
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // scenarios
  task automatic s_defaults();
    rc(5'h00, 16'h1000);
    rc(5'h11, 16'h0000);
    rc(5'h12, 16'h0000);
    rc(5'h13, 16'h0000);
    rc(5'h1A, 16'h0000);
    chk({15'h0, p_oe}, 16'h0000);
  endtask : s_defaults
  // disabled source ignored; one read clears both status words
  task automatic s_irq();
    i_host.wr(5'h12, 16'h0008);
    i_host.wr(5'h13, 16'h0002);
    pulse(16'h0010);
    rc(5'h12, 16'h0008);
    i_host.wr(5'h11, 16'h0003);
    pulse(16'h0208);
    settle(3);
    chk({14'h0, p_oe, p_out}, 16'h0002);
    rc(5'h12, 16'h0808);
    rc(5'h13, 16'h0002);
    settle(3);
    chk({14'h0, p_oe, p_out}, 16'h0003);
    i_host.wr(5'h11, 16'h0007);
    pulse(16'h0008);
    settle(3);
    chk({15'h0, p_out}, 16'h0001);
    rc(5'h12, 16'h0808);
    i_host.wr(5'h11, 16'h0000);
    settle(1);
    chk({15'h0, pd}, 16'h0000);
  endtask : s_irq
  task automatic s_power();
    logic [15:0] e;
    i_host.o_pin_low = 1'b1;
    settle(3);
    chk({15'h0, pd}, 16'h0001);
    i_host.o_pin_low = 1'b0;
    settle(3);
    chk({15'h0, pd}, 16'h0000);
    i_host.wr(5'h00, 16'h1800);
    settle(2);
    chk({15'h0, pd}, 16'h0001);
    rc(5'h00, 16'h1800);
    i_host.wr(5'h00, 16'h1000);
    for (int m = 0; m < 8; m++) begin
      i_host.wr(5'h11, {1'b0, m[2], m[1:0], 12'h000});
      settle(2);
      e = m[2] ? {13'h0, m[1:0] == 2'h1, m[1:0] == 2'h2, m[1:0] == 2'h3}
        : 16'h0000;
      chk({13'h0, pd, lpa, lpp}, e);
    end
    i_host.wr(5'h11, 16'h0000);
    settle(2);
    chk({13'h0, pd, lpa, lpp}, 16'h0000);
  endtask : s_power
  task automatic s_soft();
    int a0 = an_cnt;
    i_host.wr(5'h12, 16'h00FF);
    i_host.wr(5'h00, 16'h9800);
    i_host.soft_wait();
    rc(5'h00, 16'h1000);
    rc(5'h12, 16'h00FF);
    chk(16'(an_cnt - a0), 16'h0001);
    strap = 1'b0;
    i_host.wr(5'h11, 16'h0001);
    i_host.wr(5'h1F, 16'h4000);
    settle(1);
    chk({15'h0, cr}, 16'h0001);
    i_host.soft_wait();
    rc(5'h11, 16'h0001);
    chk(16'(an_cnt - a0), 16'h0001);
    i_host.wr(5'h1F, 16'h8000);
    rc(5'h1F, 16'h8000);
    i_host.soft_wait();
    rc(5'h11, 16'h0000);
    rc(5'h12, 16'h0000);
    rc(5'h00, 16'h1000);
    chk(16'(an_cnt - a0), 16'h0002);
  endtask : s_soft
  // strap now low and pin held low across the reset pulse
  task automatic s_hw();
    int a0 = an_cnt;
    i_host.o_pin_low = 1'b1;
    i_host.hw_reset();
    settle(2);
    chk({14'h0, pd, cr}, 16'h0003);
    rc(5'h00, 16'h0000);
    i_host.o_pin_low = 1'b0;
    settle(RDC + 4);
    chk({14'h0, pd, cr}, 16'h0000);
    chk(16'(an_cnt - a0), 16'h0000);
  endtask : s_hw
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    settle(RDC + 5);
    s_defaults();
    s_irq();
    s_power();
    s_soft();
    s_hw();
    wrap_up();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule : test_phy_reset_power_irq_ctrl
bind prpi_ctrl prpi_ctrl_chk #(.RESET_DONE_CYCLES(RESET_DONE_CYCLES)) i_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_hw_resetn(i_hw_resetn),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_pin_in(i_pin_in), .o_pin_oe(o_pin_oe),
  .o_circuit_reset(o_circuit_reset), .o_autoneg_start(o_autoneg_start),
  .o_power_down(o_power_down), .o_low_power_active(o_low_power_active),
  .o_low_power_passive(o_low_power_passive));
`default_nettype wire
